// ---- dac_clk_pkg.sv ----
// shared constants, types and decode functions for the dac clock and reset control
//=============================================================
// Operation
// RULE1 - other party supplies a free-running system clock
// RULE2 - system clock is 128 to 1152 times rate
// RULE3 - some clock and rate pairings are unavailable
// RULE4 - auto mode picks rate from clock ratio
// RULE5 - single rate modulates x128 except 128x/192x
// RULE6 - dual rate modulates x64
// RULE7 - quad rate modulates x32
// RULE8 - forced mode accepted for permitted ratios only
// RULE9 - filter and modulator ratio pairs per mode
// RULE10 - 128x or 192x always uses quad filter
// RULE11 - reset released after 3846 system clocks
// RULE12 - outputs mid-scale until release, then data
// RULE13 - no sync keeps reset, resync repeats release
// RULE14 - reset pin low holds full power-down
// RULE15 - pin fall under sync clears all state
// RULE16 - pin assertion forces outputs to ground
// RULE17 - pin return high repeats release sequence
// RULE18 - other party drives bit and word clocks
// RULE19 - ratio measured as clocks per word period
// RULE20 - release count restarts on pin or sync loss
package dac_clk_pkg;

	//=============================================================
	// clock ratio
	typedef enum logic [2:0] {
		R128  = 3'h0,
		R192  = 3'h1,
		R256  = 3'h2,
		R384  = 3'h3,
		R512  = 3'h4,
		R768  = 3'h5,
		R1152 = 3'h6
	} ratio_t;

	localparam logic [10:0] CYC_128      = 11'h080;
	localparam logic [10:0] CYC_192      = 11'h0c0;
	localparam logic [10:0] CYC_256      = 11'h100;
	localparam logic [10:0] CYC_384      = 11'h180;
	localparam logic [10:0] CYC_512      = 11'h200;
	localparam logic [10:0] CYC_768      = 11'h300;
	localparam logic [10:0] CYC_1152     = 11'h480;
	// a word period longer than the largest ratio means the word clock stalled
	localparam logic [10:0] CYC_TIMEOUT  = 11'h481;
	// bit clock runs at 64 periods per word period, so its divider is the ratio shifted by this
	localparam int          BIT_SHIFT    = 6;
	localparam logic [11:0] RELEASE_CYC  = 12'hf06;

	//=============================================================
	// modes and oversampling
	typedef enum logic [1:0] {
		SEL_AUTO   = 2'h0,
		SEL_SINGLE = 2'h1,
		SEL_DUAL   = 2'h2,
		SEL_QUAD   = 2'h3
	} mode_sel_t;

	typedef enum logic [1:0] {
		RATE_SINGLE = 2'h0,
		RATE_DUAL   = 2'h1,
		RATE_QUAD   = 2'h2
	} samp_mode_t;

	typedef enum logic {
		FILT_X4 = 1'h0,
		FILT_X8 = 1'h1
	} filt_osr_t;

	typedef enum logic [1:0] {
		MOD_X32  = 2'h0,
		MOD_X64  = 2'h1,
		MOD_X128 = 2'h2
	} mod_osr_t;

	typedef enum logic [1:0] {
		LEVEL_COMMON_MODE = 2'h0,
		LEVEL_GROUND      = 2'h1,
		LEVEL_DATA        = 2'h2
	} out_level_t;

	typedef enum logic [2:0] {
		ST_HOLD = 3'b001,
		ST_RUN  = 3'b010,
		ST_PIN  = 3'b100
	} rst_state_t;

	localparam logic [1:0] STABLE_RST = 2'h0;
	localparam logic       PIN_RST    = 1'h1;

	//=============================================================
	// decode functions
	function automatic logic [10:0] ratio_cycles(input ratio_t r);
		case (r)
			R128:    ratio_cycles = CYC_128;
			R192:    ratio_cycles = CYC_192;
			R256:    ratio_cycles = CYC_256;
			R384:    ratio_cycles = CYC_384;
			R512:    ratio_cycles = CYC_512;
			R768:    ratio_cycles = CYC_768;
			default: ratio_cycles = CYC_1152;
		endcase
	endfunction : ratio_cycles

	// returns {valid, ratio}
	function automatic logic [3:0] ratio_of_count(input logic [10:0] c);
		if (c == CYC_128)       ratio_of_count = {1'h1, R128};
		else if (c == CYC_192)  ratio_of_count = {1'h1, R192};
		else if (c == CYC_256)  ratio_of_count = {1'h1, R256};
		else if (c == CYC_384)  ratio_of_count = {1'h1, R384};
		else if (c == CYC_512)  ratio_of_count = {1'h1, R512};
		else if (c == CYC_768)  ratio_of_count = {1'h1, R768};
		else if (c == CYC_1152) ratio_of_count = {1'h1, R1152};
		else                    ratio_of_count = {1'h0, R128};
	endfunction : ratio_of_count

endpackage : dac_clk_pkg

// ---- dac_link_if.sv ----
// audio clock and reset pins between the digital audio processor and the converter
`timescale 1ns/10ps
interface dac_link_if;
	logic bit_clock;
	logic word_clock;
	logic reset_pin_b;

	modport device (
		input bit_clock,
		input word_clock,
		input reset_pin_b
	);

	modport host (
		output bit_clock,
		output word_clock,
		output reset_pin_b
	);
endinterface : dac_link_if

// ---- dac_clk_host.sv ----
// processor end: makes bit and word clocks from the system clock and drives the reset pin
`timescale 1ns/10ps
module dac_clk_host (
	input  wire logic                core_clk,
	input  wire logic                rst_b,
	dac_link_if.host                 link,
	input  wire dac_clk_pkg::ratio_t ratio_sel,
	input  wire logic                clocks_on,
	input  wire logic                reset_hold,
	output logic                     frame_start
);

	//=============================================================
	// frame timing
	dac_clk_pkg::ratio_t ratio_q;
	logic [10:0]         wcnt_q;
	logic [10:0]         bcnt_q;
	logic                word_q;
	logic                bit_q;
	logic                pin_q;
	logic                start_q;

	wire logic [10:0] wper  = dac_clk_pkg::ratio_cycles(ratio_q);
	wire logic [10:0] bper  = wper >> dac_clk_pkg::BIT_SHIFT;
	wire logic        wlast = (wcnt_q == wper - 11'h001);
	wire logic        blast = (bcnt_q == bper - 11'h001) | wlast;
	// a new ratio is taken only at a frame edge or while clocks_on is low, so every frame stays a whole multiple
	wire logic        at_edge = wlast | ~clocks_on;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			ratio_q <= dac_clk_pkg::R512;
			wcnt_q  <= 11'h000;
			bcnt_q  <= 11'h000;
		end else begin
			if (at_edge) begin
				// only permitted clock and rate pairings are asked for here
				ratio_q <= ratio_sel; // [RULE2] [RULE3]
			end
			wcnt_q <= (at_edge) ? 11'h000 : wcnt_q + 11'h001;
			bcnt_q <= (blast | ~clocks_on) ? 11'h000 : bcnt_q + 11'h001;
		end
	end

	//=============================================================
	// pins
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			word_q  <= 1'h0;
			bit_q   <= 1'h0;
			pin_q   <= 1'h0;
			start_q <= 1'h0;
		end else begin
			word_q  <= clocks_on & (wcnt_q < (wper >> 1)); // [RULE18]
			bit_q   <= clocks_on & (bcnt_q < (bper >> 1)); // [RULE18]
			pin_q   <= ~reset_hold; // [RULE14]
			start_q <= clocks_on & (wcnt_q == 11'h000);
		end
	end

	// core_clk itself is the free-running system clock the converter needs [RULE1]
	assign link.word_clock  = word_q;
	assign link.bit_clock   = bit_q;
	assign link.reset_pin_b = pin_q;
	assign frame_start      = start_q;

endmodule : dac_clk_host

// ---- dac_clk_device.sv ----
// converter end: clock ratio detection, sampling mode selection and reset sequencing
`timescale 1ns/10ps
module dac_clk_device (
	input  wire logic                     core_clk,
	input  wire logic                     rst_b,
	dac_link_if.device                    link,
	input  wire dac_clk_pkg::mode_sel_t   forced_mode,
	output dac_clk_pkg::samp_mode_t       sample_mode,
	output dac_clk_pkg::filt_osr_t        filter_osr,
	output dac_clk_pkg::mod_osr_t         modulator_osr,
	output logic                          quad_filter,
	output dac_clk_pkg::ratio_t           ratio,
	output logic                          clock_sync,
	output logic                          internal_reset,
	output logic                          power_down,
	output logic                          clear_pulse,
	output dac_clk_pkg::out_level_t       channel_level
);

	//=============================================================
	// pin synchronisers: index 0 word clock, 1 bit clock, 2 reset pin
	wire logic [2:0] pins_in = {link.reset_pin_b, link.bit_clock, link.word_clock};
	logic [2:0]      s1_q;
	logic [2:0]      s2_q;
	logic [2:0]      s3_q;
	logic [2:0]      stable_q;
	wire logic [2:0] agree = ~(s2_q ^ s3_q);

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			// the reset pin idles high so power-on does not look like a pin reset
			localparam logic INIT = (gi == 2) ? dac_clk_pkg::PIN_RST : 1'h0;
			always_ff @(posedge core_clk or negedge rst_b) begin
				if (!rst_b) begin
					s1_q[gi]     <= INIT;
					s2_q[gi]     <= INIT;
					s3_q[gi]     <= INIT;
					stable_q[gi] <= INIT;
				end else begin
					s1_q[gi] <= pins_in[gi];
					s2_q[gi] <= s1_q[gi];
					s3_q[gi] <= s2_q[gi];
					if (agree[gi]) begin
						stable_q[gi] <= s2_q[gi];
					end
				end
			end
		end
	endgenerate

	wire logic word_rise = agree[0] & s2_q[0] & ~stable_q[0];
	// bit clock may run at two system clocks a period, so activity is any change seen
	wire logic bit_act   = ~agree[1];
	wire logic pin_low   = ~stable_q[2];
	wire logic pin_fall  = agree[2] & ~s2_q[2] & stable_q[2];

	//=============================================================
	// ratio measurement and synchronisation
	logic [10:0]         per_q;
	logic                have_edge_q;
	logic                bit_seen_q;
	logic                sync_q;
	dac_clk_pkg::ratio_t ratio_q;

	wire logic [3:0]          meas     = dac_clk_pkg::ratio_of_count(per_q);
	wire logic                meas_ok  = meas[3]; // [RULE2]
	wire dac_clk_pkg::ratio_t meas_r   = dac_clk_pkg::ratio_t'(meas[2:0]);
	wire logic                timeout  = (per_q == dac_clk_pkg::CYC_TIMEOUT);
	// a jump between two valid ratios also counts as a lost lock for one period
	wire logic                jump     = sync_q & (meas_r != ratio_q);
	wire logic                good_per = have_edge_q & meas_ok & bit_seen_q & ~jump;
	wire logic                sync_d   = pin_low ? 1'h0 :
	                                     word_rise ? good_per :
	                                     timeout ? 1'h0 : sync_q;
	wire logic                sync_loss = sync_q & ~sync_d;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			per_q       <= 11'h000;
			have_edge_q <= 1'h0;
			bit_seen_q  <= 1'h0;
			sync_q      <= 1'h0;
			ratio_q     <= dac_clk_pkg::R512;
		end else begin
			if (word_rise) begin
				per_q <= 11'h001; // [RULE19]
			end else if (!timeout) begin
				per_q <= per_q + 11'h001; // [RULE19]
			end
			if (pin_low) begin
				have_edge_q <= 1'h0; // [RULE15]
			end else if (word_rise) begin
				have_edge_q <= 1'h1;
			end
			if (word_rise) begin
				bit_seen_q <= 1'h0;
			end else if (bit_act) begin
				bit_seen_q <= 1'h1;
			end
			sync_q <= sync_d; // [RULE19]
			if (pin_low) begin
				ratio_q <= dac_clk_pkg::R512; // [RULE15]
			end else if (word_rise & good_per) begin
				ratio_q <= meas_r;
			end
		end
	end

	//=============================================================
	// sampling mode and oversampling selection
	wire logic is_low  = (ratio_q == dac_clk_pkg::R128) | (ratio_q == dac_clk_pkg::R192);
	wire logic is_mid  = (ratio_q == dac_clk_pkg::R256) | (ratio_q == dac_clk_pkg::R384);
	wire logic is_high = ~is_low & ~is_mid;

	// a forced choice outside the permitted ratio set falls back to automatic
	wire logic force_ok = (forced_mode == dac_clk_pkg::SEL_SINGLE) |
	                      ((forced_mode == dac_clk_pkg::SEL_DUAL) & ~is_high) |
	                      ((forced_mode == dac_clk_pkg::SEL_QUAD) & is_low); // [RULE8]

	wire dac_clk_pkg::samp_mode_t auto_mode = is_high ? dac_clk_pkg::RATE_SINGLE :
	                                          is_mid  ? dac_clk_pkg::RATE_DUAL :
	                                                    dac_clk_pkg::RATE_QUAD; // [RULE4]

	wire dac_clk_pkg::samp_mode_t forced_rate =
		(forced_mode == dac_clk_pkg::SEL_SINGLE) ? dac_clk_pkg::RATE_SINGLE :
		(forced_mode == dac_clk_pkg::SEL_DUAL)   ? dac_clk_pkg::RATE_DUAL :
		                                           dac_clk_pkg::RATE_QUAD;

	wire dac_clk_pkg::samp_mode_t mode_d = force_ok ? forced_rate : auto_mode; // [RULE8]

	// filter ratio follows the clock ratio alone in every mode
	wire dac_clk_pkg::filt_osr_t filt_d = is_low ? dac_clk_pkg::FILT_X4 :
	                                               dac_clk_pkg::FILT_X8; // [RULE9]

	wire dac_clk_pkg::mod_osr_t mod_d =
		(mode_d == dac_clk_pkg::RATE_SINGLE) ?
			(is_low ? dac_clk_pkg::MOD_X64 : dac_clk_pkg::MOD_X128) : // [RULE5] [RULE9]
		(mode_d == dac_clk_pkg::RATE_DUAL) ? dac_clk_pkg::MOD_X64 :   // [RULE6] [RULE9]
		                                     dac_clk_pkg::MOD_X32;    // [RULE7] [RULE9]

	//=============================================================
	// reset release sequencing
	dac_clk_pkg::rst_state_t state_q;
	dac_clk_pkg::rst_state_t state_d;
	logic [11:0]             rel_q;

	wire logic rel_done = (rel_q == dac_clk_pkg::RELEASE_CYC);

	always_comb begin
		state_d = state_q;
		case (state_q)
			dac_clk_pkg::ST_HOLD: begin
				if (rel_done & sync_q) begin
					state_d = dac_clk_pkg::ST_RUN; // [RULE11] [RULE12]
				end
			end
			dac_clk_pkg::ST_RUN: begin
				if (!sync_d) begin
					state_d = dac_clk_pkg::ST_HOLD; // [RULE13]
				end
			end
			dac_clk_pkg::ST_PIN: begin
				state_d = dac_clk_pkg::ST_HOLD; // [RULE17]
			end
			default: begin
				state_d = dac_clk_pkg::ST_HOLD;
			end
		endcase
		// the fall itself already grounds the outputs, in the cycle of the clear pulse
		if (pin_low | pin_fall) begin
			state_d = dac_clk_pkg::ST_PIN; // [RULE14] [RULE16]
		end
	end

	wire dac_clk_pkg::out_level_t level_d =
		(state_d == dac_clk_pkg::ST_PIN) ? dac_clk_pkg::LEVEL_GROUND :      // [RULE16]
		(state_d == dac_clk_pkg::ST_RUN) ? dac_clk_pkg::LEVEL_DATA :        // [RULE12]
		                                   dac_clk_pkg::LEVEL_COMMON_MODE;  // [RULE12]

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rel_q   <= 12'h000;
			state_q <= dac_clk_pkg::ST_HOLD;
		end else begin
			if (pin_low | sync_loss) begin
				rel_q <= 12'h000; // [RULE20] [RULE17]
			end else if (!rel_done) begin
				rel_q <= rel_q + 12'h001; // [RULE11]
			end
			state_q <= state_d;
		end
	end

	//=============================================================
	// registered outputs
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sample_mode    <= dac_clk_pkg::RATE_SINGLE;
			filter_osr     <= dac_clk_pkg::FILT_X8;
			modulator_osr  <= dac_clk_pkg::MOD_X128;
			quad_filter    <= 1'h0;
			ratio          <= dac_clk_pkg::R512;
			clock_sync     <= 1'h0;
			internal_reset <= 1'h1;
			power_down     <= 1'h1;
			clear_pulse    <= 1'h0;
			channel_level  <= dac_clk_pkg::LEVEL_COMMON_MODE;
		end else begin
			sample_mode    <= mode_d;
			filter_osr     <= filt_d;
			modulator_osr  <= mod_d;
			quad_filter    <= is_low; // [RULE10]
			ratio          <= ratio_q;
			clock_sync     <= sync_q;
			internal_reset <= (state_d != dac_clk_pkg::ST_RUN); // [RULE13] [RULE15]
			power_down     <= (state_d != dac_clk_pkg::ST_RUN); // [RULE14]
			clear_pulse    <= pin_fall & sync_q; // [RULE15]
			channel_level  <= level_d;
		end
	end

endmodule : dac_clk_device

// ---- dac_clk_props.sv ----
// concurrent checks on the clock link and the converter status outputs
`timescale 1ns/10ps
module dac_clk_props (
	input wire logic                    core_clk,
	input wire logic                    rst_b,
	input wire logic                    bit_clock,
	input wire logic                    word_clock,
	input wire logic                    reset_pin_b,
	input wire dac_clk_pkg::mode_sel_t  forced_mode,
	input wire dac_clk_pkg::samp_mode_t sample_mode,
	input wire dac_clk_pkg::filt_osr_t  filter_osr,
	input wire dac_clk_pkg::mod_osr_t   modulator_osr,
	input wire logic                    quad_filter,
	input wire dac_clk_pkg::ratio_t     ratio,
	input wire logic                    clock_sync,
	input wire logic                    internal_reset,
	input wire logic                    power_down,
	input wire logic                    clear_pulse,
	input wire dac_clk_pkg::out_level_t channel_level
);
	// two cycles of slack: the pin passes a synchroniser before the count starts
	localparam int MIN_HI = 3844;
	logic [11:0]   hi_q;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	//==========
	// run length of the pin held high
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			hi_q <= 12'h000;
		else if (!reset_pin_b)
			hi_q <= 12'h000;
		else if (hi_q != 12'hfff)
			hi_q <= hi_q + 12'h001;
	end

	//==========
	// mode selection
	quad_filt_a: assert property (
		ratio < dac_clk_pkg::R256 |-> quad_filter && filter_osr == dac_clk_pkg::FILT_X4)
		else $error("quad filter not applied");
	// ratio shows the locked ratio one cycle late, so it is read a cycle after the mode input
	auto_single_a: assert property (
		forced_mode == dac_clk_pkg::SEL_AUTO ##1 ratio > dac_clk_pkg::R384
		|-> sample_mode == dac_clk_pkg::RATE_SINGLE && modulator_osr == dac_clk_pkg::MOD_X128)
		else $error("auto single mode wrong");
	auto_dual_a: assert property (
		forced_mode == dac_clk_pkg::SEL_AUTO ##1 ratio inside {dac_clk_pkg::R256, dac_clk_pkg::R384}
		|-> sample_mode == dac_clk_pkg::RATE_DUAL && modulator_osr == dac_clk_pkg::MOD_X64)
		else $error("auto dual mode wrong");
	forced_quad_a: assert property (
		forced_mode == dac_clk_pkg::SEL_QUAD ##1 ratio < dac_clk_pkg::R256
		|-> sample_mode == dac_clk_pkg::RATE_QUAD && modulator_osr == dac_clk_pkg::MOD_X32)
		else $error("forced quad mode wrong");
	bad_force_a: assert property (
		forced_mode == dac_clk_pkg::SEL_QUAD ##1 ratio > dac_clk_pkg::R192
		|-> sample_mode != dac_clk_pkg::RATE_QUAD)
		else $error("illegal forced mode taken");

	//==========
	// reset sequencing
	pin_low_a: assert property (
		// lock status trails the grounded outputs by two more cycles
		!reset_pin_b [*7] |-> channel_level == dac_clk_pkg::LEVEL_GROUND && power_down
		&& internal_reset && !clock_sync)
		else $error("pin low without power-down");
	clear_once_a: assert property (
		clear_pulse |-> $past(clock_sync) && channel_level == dac_clk_pkg::LEVEL_GROUND
		##1 !clear_pulse)
		else $error("clear pulse wrong");
	release_a: assert property (
		$fell(internal_reset) |-> hi_q >= MIN_HI && clock_sync)
		else $error("release too early");
	run_data_a: assert property (
		!internal_reset |-> channel_level == dac_clk_pkg::LEVEL_DATA && !power_down)
		else $error("run without data output");
	no_sync_a: assert property (
		!clock_sync [*3] |-> internal_reset && channel_level != dac_clk_pkg::LEVEL_DATA)
		else $error("running without sync");
	bit_active_a: assert property (
		$rose(word_clock) |-> ##[1:18] $changed(bit_clock))
		else $error("bit clock idle in frame");
endmodule : dac_clk_props

// ---- tb.sv ----
// self-checking bench: processor end and converter end joined by one link
`timescale 1ns/10ps
module tb;
	//==========
	// signals
	logic                    core_clk, rst_b, clocks_on, reset_hold;
	logic                    quad_filter, clock_sync, internal_reset, power_down, clear_pulse;
	logic                    sync2, ireset2, frame_start;
	dac_clk_pkg::ratio_t     ratio_sel, ratio;
	dac_clk_pkg::mode_sel_t  forced_mode;
	dac_clk_pkg::samp_mode_t sample_mode;
	dac_clk_pkg::filt_osr_t  filter_osr;
	dac_clk_pkg::mod_osr_t   modulator_osr;
	dac_clk_pkg::out_level_t channel_level;
	int                      errors, n_compared, n, hi, wc, bc, fc;
	int                      n_clear = 0;
	int                      bad_cnt = 0;
	int                      cyc [7] = '{128, 192, 256, 384, 512, 768, 1152};
	logic                    lw, lb;

	dac_link_if link ();
	dac_link_if link2 ();

	//==========
	// instances
	dac_clk_host dac_clk_host_inst (.core_clk, .rst_b, .link, .ratio_sel, .clocks_on,
		.reset_hold, .frame_start);
	dac_clk_device dac_clk_device_inst (.core_clk, .rst_b, .link, .forced_mode, .sample_mode,
		.filter_osr, .modulator_osr, .quad_filter, .ratio, .clock_sync, .internal_reset,
		.power_down, .clear_pulse, .channel_level);
	dac_clk_props dac_clk_props_inst (.core_clk, .rst_b, .bit_clock(link.bit_clock),
		.word_clock(link.word_clock), .reset_pin_b(link.reset_pin_b), .forced_mode,
		.sample_mode, .filter_osr, .modulator_osr, .quad_filter, .ratio, .clock_sync,
		.internal_reset, .power_down, .clear_pulse, .channel_level);
	// second converter fed a 300-cycle word period, which is no supported ratio
	dac_clk_device dac_clk_device_inst2 (.core_clk, .rst_b, .link(link2),
		.forced_mode(dac_clk_pkg::SEL_AUTO), .sample_mode(), .filter_osr(), .modulator_osr(),
		.quad_filter(), .ratio(), .clock_sync(sync2), .internal_reset(ireset2),
		.power_down(), .clear_pulse(), .channel_level());
	assign link2.word_clock = bad_cnt < 150;
	assign link2.bit_clock = bad_cnt[0];
	assign link2.reset_pin_b = rst_b;

	always @(negedge core_clk) bad_cnt <= (bad_cnt + 1) % 300;
	always @(posedge core_clk) n_clear <= n_clear + (clear_pulse === 1'b1);

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	//==========
	// tasks
	task automatic check(input bit ok, input string msg);
		n_compared++;
		if (!ok) begin
			$display("wrong value at %0t ns: %s", $time, msg);
			errors++;
		end
	endtask : check

	task automatic wait_release(output int cnt);
		cnt = 0;
		while (internal_reset !== 1'b0 && cnt < 9000) begin
			@(negedge core_clk);
			cnt++;
		end
	endtask : wait_release

	// expected {mode, filter, modulator} in package encoding
	function automatic logic [4:0] want(input int r, input int m);
		bit q, d;
		q = r < 2;
		d = r < 4;
		if ((m == 2 && !d) || (m == 3 && !q))
			m = 0;
		case (m)
			0: want = q ? 5'h10 : d ? 5'h0d : 5'h06;
			1: want = {2'h0, ~q, q ? 2'h1 : 2'h2};
			2: want = {2'h1, ~q, 2'h1};
			default: want = 5'h10;
		endcase
	endfunction : want

	task automatic complete_run;
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run

	//==========
	// tests
	initial begin
		#(100000 * 25);
		errors++;
		complete_run();
	end

	initial begin
		rst_b = 1'b0;
		clocks_on = 1'b1;
		reset_hold = 1'b0;
		ratio_sel = dac_clk_pkg::R512;
		forced_mode = dac_clk_pkg::SEL_AUTO;
		errors = 0;
		n_compared = 0;
		repeat (5) @(negedge core_clk);
		rst_b = 1'b1;
		wait_release(n);
		check(n >= 3846 && n <= 3848, "power-on release count");
		check(channel_level === dac_clk_pkg::LEVEL_DATA && power_down === 1'b0, "run");
		for (int r = 0; r < 7; r++) begin
			ratio_sel = dac_clk_pkg::ratio_t'(r);
			for (n = 0; n < 12000 && !(ratio === ratio_sel && internal_reset === 1'b0); n++)
				@(negedge core_clk);
			check(ratio === ratio_sel && clock_sync === 1'b1, "lock on ratio");
			@(posedge link.word_clock);
			@(negedge core_clk);
			lw = link.word_clock;
			lb = link.bit_clock;
			hi = 0;
			wc = 0;
			bc = 0;
			fc = 0;
			// a whole word period holds a whole number of bit periods, so phase does not matter
			for (n = 0; n < cyc[r]; n++) begin
				@(negedge core_clk);
				hi += link.word_clock;
				wc += link.word_clock !== lw;
				bc += link.bit_clock !== lb;
				fc += frame_start === 1'b1;
				lw = link.word_clock;
				lb = link.bit_clock;
			end
			check(hi == cyc[r] / 2 && wc == 2 && bc == 128 && fc == 1, "clock shape");
			for (int m = 0; m < 4; m++) begin
				forced_mode = dac_clk_pkg::mode_sel_t'(m);
				repeat (2) @(negedge core_clk);
				check({sample_mode, filter_osr, modulator_osr} === want(r, m), "mode");
				check(quad_filter === (r < 2), "quad filter");
			end
			forced_mode = dac_clk_pkg::SEL_AUTO;
		end
		clocks_on = 1'b0;
		for (n = 0; n < 1300 && clock_sync !== 1'b0; n++)
			@(negedge core_clk);
		repeat (3) @(negedge core_clk);
		check(internal_reset === 1'b1 && channel_level === dac_clk_pkg::LEVEL_COMMON_MODE
			&& clock_sync === 1'b0 && link.word_clock === 1'b0, "clock loss");
		clocks_on = 1'b1;
		wait_release(n);
		check(n >= 3840 && n < 9000, "release after resync");
		wc = n_clear;
		reset_hold = 1'b1;
		repeat (5) @(negedge core_clk);
		check(channel_level === dac_clk_pkg::LEVEL_GROUND, "ground on pin");
		repeat (55) @(negedge core_clk);
		check(power_down === 1'b1 && internal_reset === 1'b1 && n_clear - wc == 1, "pin");
		reset_hold = 1'b0;
		repeat (6) @(negedge core_clk);
		check(channel_level === dac_clk_pkg::LEVEL_COMMON_MODE, "mid after pin");
		wait_release(n);
		check(n >= 3840 && n < 9000, "release after pin");
		check(sync2 === 1'b0 && ireset2 === 1'b1, "bad word period");
		complete_run();
	end
endmodule : tb
